// ### rtl/cantms_top.v
// Transmit mailbox status register with APB slave and interrupt.
// Assumes engine inputs are synchronous to pclk, one-cycle pulses.
//
// Contract
// R1: Set request-done flag when request finishes.
// R2: Clear request-done flag on accepted request.
// R3: Write one clears flags; zero leaves them.
// R4: Set success flag on successful transmit.
// R5: Set arbitration-lost flag on lost arbitration.
// R6: Set error flag on failed transmit.
// R7: Software sets abort; hardware clears after discard.
// R8: Ignore abort for an empty mailbox.
// R9: Free index: all empty lowest, else next.
// R10: Empty flags at bits 26 to 28.
// R11: Lowest-priority flags at bits 29 to 31.
// R12: Lowest-priority flags zero with one waiting.
// R13: Status at offset 0x08, reset 0x1C000000.
// R14: Reserved bits read zero, writes ignored.
// R15: Hardware set wins over software clear.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`include "cantms_consts.vh"

module cantms_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [2:0] tx_req_accept,
    input wire [2:0] tx_req_finish,
    input wire [2:0] tx_ok_evt,
    input wire [2:0] tx_arb_lost_evt,
    input wire [2:0] tx_fail_evt,
    input wire [2:0] tx_msg_discarded,
    input wire [2:0] tx_lowest_prio,
    output reg [2:0] abort_req,
    output reg [2:0] mbx_empty,
    output reg irq
);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire setup_phase; // First cycle of a transfer
    wire access_done; // Edge at which transfer completes
    wire wr_take; // Write takes effect now
    wire hit_status; // Status register selected
    wire hit_irq_stat; // Interrupt status selected
    wire hit_irq_clr; // Interrupt clear selected
    wire hit_irq_en; // Interrupt enable selected
    wire hit_any; // Any mapped register
    wire [31:0] wmask; // Write data gated by strobes

    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_take = access_done & pwrite & ~pslverr;
    assign hit_status = (paddr == `CANTMS_OFF_STATUS); // [R13]
    assign hit_irq_stat = (paddr == `CANTMS_OFF_IRQ_STAT);
    assign hit_irq_clr = (paddr == `CANTMS_OFF_IRQ_CLR);
    assign hit_irq_en = (paddr == `CANTMS_OFF_IRQ_EN);
    assign hit_any = hit_status | hit_irq_stat | hit_irq_clr | hit_irq_en;

    // Byte strobes gate each lane of the write data
    assign wmask = pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // ----------------------------------------
    // Per-mailbox flags
    // ----------------------------------------
    wire [2:0] done_w; // Request completed
    wire [2:0] ok_w; // Transmit succeeded
    wire [2:0] arb_w; // Arbitration lost
    wire [2:0] fail_w; // Transmit error
    wire [2:0] abort_w; // Abort pending
    wire [2:0] pending_w; // Message waiting
    wire [2:0] clr_done_w; // Write-one clear pulses
    wire [2:0] clr_ok_w;
    wire [2:0] clr_arb_w;
    wire [2:0] clr_fail_w;
    wire [2:0] set_abort_w; // Write-one abort pulses

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_mbx
            // Clear strobes only on a completed status write
            assign clr_done_w[gi] = wr_take & hit_status &
                wmask[gi*`CANTMS_MBX_STRIDE + `CANTMS_BIT_DONE]; // [R3]
            assign clr_ok_w[gi] = wr_take & hit_status &
                wmask[gi*`CANTMS_MBX_STRIDE + `CANTMS_BIT_OK]; // [R3]
            assign clr_arb_w[gi] = wr_take & hit_status &
                wmask[gi*`CANTMS_MBX_STRIDE + `CANTMS_BIT_ARB]; // [R3]
            assign clr_fail_w[gi] = wr_take & hit_status &
                wmask[gi*`CANTMS_MBX_STRIDE + `CANTMS_BIT_FAIL]; // [R3]
            assign set_abort_w[gi] = wr_take & hit_status &
                wmask[gi*`CANTMS_MBX_STRIDE + `CANTMS_BIT_ABORT]; // [R7]

            cantms_mbx_flags u_flags (
                .pclk(pclk),
                .presetn(presetn),
                .req_accept(tx_req_accept[gi]),
                .req_finish(tx_req_finish[gi]),
                .evt_ok(tx_ok_evt[gi]),
                .evt_arb_lost(tx_arb_lost_evt[gi]),
                .evt_fail(tx_fail_evt[gi]),
                .msg_discarded(tx_msg_discarded[gi]),
                .clr_done(clr_done_w[gi]),
                .clr_ok(clr_ok_w[gi]),
                .clr_arb(clr_arb_w[gi]),
                .clr_fail(clr_fail_w[gi]),
                .set_abort(set_abort_w[gi]),
                .done_reg(done_w[gi]),
                .ok_reg(ok_w[gi]),
                .arb_reg(arb_w[gi]),
                .fail_reg(fail_w[gi]),
                .abort_reg(abort_w[gi]),
                .pending_reg(pending_w[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Derived read-only fields
    // ----------------------------------------
    wire [2:0] empty_w; // Mailbox holds nothing
    wire [1:0] wait_cnt; // Number of waiting mailboxes
    reg [1:0] free_idx; // Free mailbox index
    wire [2:0] lowp_w; // Lowest-priority flags

    assign empty_w = ~pending_w; // [R10]
    assign wait_cnt = {1'b0, pending_w[0]} + {1'b0, pending_w[1]} + {1'b0, pending_w[2]};

    // Lowest priority only means something with two or more waiting
    assign lowp_w = (wait_cnt > 2'h1) ? (tx_lowest_prio & pending_w) : 3'h0; // [R11] [R12]

    // Index: all empty gives slot 0, else next to load
    always @*
    begin
        free_idx = `CANTMS_IDX_NONE;
        if (&empty_w) // [R9]
        begin
            free_idx = `CANTMS_IDX_ALL_EMPTY;
        end
        else if (empty_w[0])
        begin
            free_idx = 2'h0;
        end
        else if (empty_w[1])
        begin
            free_idx = 2'h1;
        end
        else if (empty_w[2])
        begin
            free_idx = 2'h2;
        end
    end

    // ----------------------------------------
    // Status word assembly
    // ----------------------------------------
    reg [31:0] status_word; // Software view of the status

    // Reserved groups stay at zero, so writes there have no effect
    always @*
    begin
        status_word = 32'h00000000; // [R14]
        status_word[`CANTMS_BIT_DONE] = done_w[0];
        status_word[`CANTMS_BIT_OK] = ok_w[0];
        status_word[`CANTMS_BIT_ARB] = arb_w[0];
        status_word[`CANTMS_BIT_FAIL] = fail_w[0];
        status_word[`CANTMS_BIT_ABORT] = abort_w[0];
        status_word[`CANTMS_MBX_STRIDE + `CANTMS_BIT_DONE] = done_w[1];
        status_word[`CANTMS_MBX_STRIDE + `CANTMS_BIT_OK] = ok_w[1];
        status_word[`CANTMS_MBX_STRIDE + `CANTMS_BIT_ARB] = arb_w[1];
        status_word[`CANTMS_MBX_STRIDE + `CANTMS_BIT_FAIL] = fail_w[1];
        status_word[`CANTMS_MBX_STRIDE + `CANTMS_BIT_ABORT] = abort_w[1];
        status_word[2*`CANTMS_MBX_STRIDE + `CANTMS_BIT_DONE] = done_w[2];
        status_word[2*`CANTMS_MBX_STRIDE + `CANTMS_BIT_OK] = ok_w[2];
        status_word[2*`CANTMS_MBX_STRIDE + `CANTMS_BIT_ARB] = arb_w[2];
        status_word[2*`CANTMS_MBX_STRIDE + `CANTMS_BIT_FAIL] = fail_w[2];
        status_word[2*`CANTMS_MBX_STRIDE + `CANTMS_BIT_ABORT] = abort_w[2];
        status_word[`CANTMS_IDX_LSB +: 2] = free_idx; // [R9]
        status_word[`CANTMS_EMPTY_LSB +: 3] = empty_w; // [R10]
        status_word[`CANTMS_LOWP_LSB +: 3] = lowp_w; // [R11]
    end

    // ----------------------------------------
    // Interrupt status, enable and clear
    // ----------------------------------------
    reg [8:0] irq_stat_reg; // Sticky event bits
    reg [8:0] irq_stat_next;
    reg [8:0] irq_en_reg; // Enable mask
    reg [8:0] irq_en_next;
    wire [8:0] irq_evt; // Events this cycle
    wire [8:0] irq_clr; // Clear-register write pulses

    assign irq_evt = {tx_fail_evt, tx_arb_lost_evt, tx_req_finish};
    assign irq_clr = (wr_take & hit_irq_clr) ? wmask[8:0] : 9'h000;

    // New events win over a clear in the same cycle
    always @*
    begin
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;
        irq_en_next = irq_en_reg;
        if (wr_take & hit_irq_en)
        begin
            irq_en_next = wmask[8:0];
        end
    end

    // Interrupt storage and level output
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_reg <= `CANTMS_RST_IRQ;
            irq_en_reg <= `CANTMS_RST_IRQ;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            irq_en_reg <= irq_en_next;
            // Level follows next state so output stays a flop
            irq <= |(irq_stat_next & irq_en_next);
        end
    end

    // ----------------------------------------
    // Mirrored outputs to the engine
    // ----------------------------------------
    // Predicted next values keep the outputs aligned with the flags
    wire [2:0] abort_next_w; // Abort after this edge
    wire [2:0] empty_next_w; // Empty after this edge

    // Abort and empty come out registered, in step with the flags
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            abort_req <= 3'h0;
            mbx_empty <= 3'h7;
        end
        else
        begin
            abort_req <= abort_next_w; // [R7]
            mbx_empty <= empty_next_w; // [R10]
        end
    end

    // Same terms as the flag cells, so mirrors never drift from the status word
    assign abort_next_w = abort_w & ~(tx_msg_discarded | tx_req_finish) |
        (set_abort_w & pending_w & ~tx_msg_discarded & ~tx_req_finish);
    assign empty_next_w = ~((pending_w & ~(tx_req_finish | tx_msg_discarded)) | tx_req_accept);

    // ----------------------------------------
    // APB response
    // ----------------------------------------
    reg [31:0] rd_mux; // Read data selection

    // Write-only clear register reads as zero
    always @*
    begin
        rd_mux = 32'h00000000;
        if (hit_status)
        begin
            rd_mux = status_word; // [R13]
        end
        else if (hit_irq_stat)
        begin
            rd_mux = {23'h000000, irq_stat_reg};
        end
        else if (hit_irq_en)
        begin
            rd_mux = {23'h000000, irq_en_reg};
        end
    end

    // No wait state: answer prepared in setup, taken in the first access cycle.
    // Read data is sampled at setup, so it trails the flags by a cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            pready <= 1'b1;
            pslverr <= ~hit_any;
            prdata <= pwrite ? 32'h00000000 : rd_mux;
        end
        else
        begin
            // Drop ready after the access edge
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

endmodule // cantms_top

// ### rtl/cantms_consts.vh
// Constants for the transmit mailbox status block.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef CANTMS_CONSTS_VH
`define CANTMS_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CANTMS_OFF_STATUS 12'h008
`define CANTMS_OFF_IRQ_STAT 12'h020
`define CANTMS_OFF_IRQ_CLR 12'h024
`define CANTMS_OFF_IRQ_EN 12'h028

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CANTMS_RST_STATUS 32'h1C000000
`define CANTMS_RST_IRQ 9'h000

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define CANTMS_MBX_STRIDE 8
`define CANTMS_BIT_DONE 0
`define CANTMS_BIT_OK 1
`define CANTMS_BIT_ARB 2
`define CANTMS_BIT_FAIL 3
`define CANTMS_BIT_ABORT 7
`define CANTMS_IDX_LSB 24
`define CANTMS_EMPTY_LSB 26
`define CANTMS_LOWP_LSB 29

// ----------------------------------------
// Interrupt layout and free index value
// ----------------------------------------
`define CANTMS_IRQ_W 9
`define CANTMS_IRQ_DONE_LSB 0
`define CANTMS_IRQ_ARB_LSB 3
`define CANTMS_IRQ_FAIL_LSB 6
`define CANTMS_IDX_ALL_EMPTY 2'h0
`define CANTMS_IDX_NONE 2'h0

`endif

// ### rtl/cantms_mbx_flags.v
// One transmit mailbox: completion, outcome, abort and pending state.
// Assumes engine events are one-cycle pulses on pclk.
`timescale 1ns/100ps

module cantms_mbx_flags (
    input wire pclk,
    input wire presetn,
    input wire req_accept,
    input wire req_finish,
    input wire evt_ok,
    input wire evt_arb_lost,
    input wire evt_fail,
    input wire msg_discarded,
    input wire clr_done,
    input wire clr_ok,
    input wire clr_arb,
    input wire clr_fail,
    input wire set_abort,
    output reg done_reg,
    output reg ok_reg,
    output reg arb_reg,
    output reg fail_reg,
    output reg abort_reg,
    output reg pending_reg
);

    // ----------------------------------------
    // Next-state terms
    // ----------------------------------------
    reg done_next; // Completion flag
    reg ok_next; // Success flag
    reg arb_next; // Arbitration loss flag
    reg fail_next; // Error flag
    reg abort_next; // Abort request
    reg pending_next; // Message waiting

    // Set beats clear for done, ok, arb and fail so no event is lost; for abort, clear wins
    always @*
    begin
        done_next = done_reg;
        if (clr_done | req_accept) // [R2] [R3]
        begin
            done_next = 1'b0;
        end
        if (req_finish) // [R1] [R15]
        begin
            done_next = 1'b1;
        end
        ok_next = ok_reg;
        if (clr_ok | evt_fail | evt_arb_lost) // [R3] [R4]
        begin
            ok_next = 1'b0;
        end
        if (evt_ok) // [R4] [R15]
        begin
            ok_next = 1'b1;
        end
        arb_next = (arb_reg & ~clr_arb) | evt_arb_lost; // [R3] [R5] [R15]
        fail_next = (fail_reg & ~clr_fail) | evt_fail; // [R3] [R6] [R15]
        // Pending: loaded by accept, freed by finish
        pending_next = pending_reg;
        if (req_finish | msg_discarded)
        begin
            pending_next = 1'b0;
        end
        if (req_accept)
        begin
            pending_next = 1'b1;
        end
        // Abort only takes hold on a waiting message
        abort_next = abort_reg;
        if (msg_discarded | req_finish | ~pending_reg) // [R7]
        begin
            abort_next = 1'b0;
        end
        if (set_abort & pending_reg & ~msg_discarded & ~req_finish) // [R7] [R8]
        begin
            abort_next = 1'b1;
        end
    end

    // Flag storage
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_reg <= 1'b0;
            ok_reg <= 1'b0;
            arb_reg <= 1'b0;
            fail_reg <= 1'b0;
            abort_reg <= 1'b0;
            pending_reg <= 1'b0;
        end
        else
        begin
            done_reg <= done_next;
            ok_reg <= ok_next;
            arb_reg <= arb_next;
            fail_reg <= fail_next;
            abort_reg <= abort_next;
            pending_reg <= pending_next;
        end
    end

endmodule // cantms_mbx_flags

// ### test/cantms_top_chk.sv
// Port checker for the transmit mailbox status block.
// Assumes it is bound onto cantms_top; one clock domain.
`timescale 1ns/100ps
module cantms_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [2:0] tx_req_accept,
    input wire [2:0] tx_req_finish,
    input wire [2:0] tx_msg_discarded,
    input wire [2:0] abort_req,
    input wire [2:0] mbx_empty
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Status read answered in this cycle
    wire st_rd = pready && !pwrite && paddr == 12'h008;
    // Finish not masked by a same-cycle accept
    wire [2:0] fin_only = tx_req_finish & ~tx_req_accept;

    a_one_wait: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    a_accept_fill: assert property (|tx_req_accept |=> (mbx_empty & $past(tx_req_accept)) == 3'h0)
        else $error("accepted mailbox still empty");
    a_finish_free: assert property (|fin_only |=> (mbx_empty & $past(fin_only)) == $past(fin_only))
        else $error("finished mailbox not empty");
    a_abort_busy: assert property ((abort_req & mbx_empty) == 3'h0) else $error("abort on empty");
    a_discard_abort: assert property (|tx_msg_discarded |=> (abort_req & $past(tx_msg_discarded)) == 3'h0)
        else $error("abort kept after discard");
    a_read_mirror: assert property (st_rd |-> prdata[28:26] == $past(mbx_empty)
        && {prdata[23], prdata[15], prdata[7]} == $past(abort_req)) else $error("status mirror mismatch");
    a_resv_zero: assert property (st_rd |-> {prdata[22:20], prdata[14:12], prdata[6:4]} == 9'h0)
        else $error("reserved bits set");
    a_lowp_single: assert property (st_rd && $countones($past(mbx_empty)) >= 2 |-> prdata[31:29] == 3'h0)
        else $error("priority flags with one waiting");
    a_index_empty: assert property (st_rd && $past(mbx_empty) == 3'h7 |-> prdata[25:24] == 2'h0)
        else $error("index wrong when all empty");
endmodule // cantms_chk

bind cantms_top cantms_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_req_accept(tx_req_accept), .tx_req_finish(tx_req_finish),
    .tx_msg_discarded(tx_msg_discarded), .abort_req(abort_req), .mbx_empty(mbx_empty)
);

// ### test/cantms_engine_model.sv
// Transmit engine model: event pulses on command, discards aborted mailboxes.
// Assumes one-cycle pulses on pclk; lowest priority is the highest pending index.
`timescale 1ns/100ps
module cantms_engine_model #(
    parameter ABORT_LAT = 6
) (
    input wire pclk,
    input wire presetn,
    input wire [2:0] abort_req,
    output reg [2:0] tx_req_accept,
    output wire [2:0] tx_req_finish,
    output reg [2:0] tx_ok_evt,
    output reg [2:0] tx_arb_lost_evt,
    output reg [2:0] tx_fail_evt,
    output reg [2:0] tx_msg_discarded,
    output wire [2:0] tx_lowest_prio
);
    reg [2:0] fin_cmd = 3'h0; // Finish on command
    reg [2:0] fin_abt; // Finish issued with the discard
    reg [2:0] pend_reg; // Mailboxes holding a message
    reg [3:0] lat_cnt; // Slow answer to an abort
    initial {tx_req_accept, tx_ok_evt, tx_arb_lost_evt, tx_fail_evt} = 12'h0;
    assign tx_req_finish = fin_cmd | fin_abt;
    assign tx_lowest_prio = pend_reg[2] ? 3'h4 : pend_reg[1] ? 3'h2 : {2'h0, pend_reg[0]};
    // One pulse of kind k: 0 accept, 1 finish, 2 ok, 3 arb lost, 4 fail
    task ev(input integer k, input [2:0] m);
    begin
        case (k)
            0: tx_req_accept <= m;
            1: fin_cmd <= m;
            2: tx_ok_evt <= m;
            3: tx_arb_lost_evt <= m;
            default: tx_fail_evt <= m;
        endcase
        @(posedge pclk);
        {tx_req_accept, fin_cmd, tx_ok_evt, tx_arb_lost_evt, tx_fail_evt} <= 15'h0;
        @(posedge pclk);
    end
    endtask
    // Pending tracking and delayed discard of aborted messages
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_reg <= 3'h0;
            lat_cnt <= 4'h0;
            tx_msg_discarded <= 3'h0;
            fin_abt <= 3'h0;
        end
        else
        begin
            pend_reg <= (pend_reg & ~tx_req_finish) | tx_req_accept;
            tx_msg_discarded <= 3'h0;
            fin_abt <= 3'h0;
            if (abort_req != 3'h0 && tx_msg_discarded == 3'h0)
            begin
                lat_cnt <= lat_cnt + 4'h1;
                if (lat_cnt == ABORT_LAT)
                begin
                    tx_msg_discarded <= abort_req;
                    fin_abt <= abort_req;
                    lat_cnt <= 4'h0;
                end
            end
        end
    end
endmodule // cantms_engine_model

// ### test/test_cantms_top.sv
// Self-checking bench for the transmit mailbox status block.
// Assumes the engine model drives every event input.
`timescale 1ns/100ps
`include "cantms_consts.vh"
module test_cantms_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [3:0] pstrb = 4'hF;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [2:0] acc, fin, okv, arb, fail, dis, lowp, abort_req, mbx_empty;
    integer n_fail = 0;
    integer checks = 0;
    integer cyc = 0;
    integer i;
    reg [31:0] st; // Expected status word
    reg [31:0] rd;
    reg err;
    localparam [11:0] ST = `CANTMS_OFF_STATUS;

    cantms_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_req_accept(acc), .tx_req_finish(fin), .tx_ok_evt(okv), .tx_arb_lost_evt(arb), .tx_fail_evt(fail),
        .tx_msg_discarded(dis), .tx_lowest_prio(lowp), .abort_req(abort_req), .mbx_empty(mbx_empty), .irq(irq));
    cantms_engine_model #(.ABORT_LAT(6)) eng (.pclk(pclk), .presetn(presetn), .abort_req(abort_req),
        .tx_req_accept(acc), .tx_req_finish(fin), .tx_ok_evt(okv), .tx_arb_lost_evt(arb),
        .tx_fail_evt(fail), .tx_msg_discarded(dis), .tx_lowest_prio(lowp));

    always #20 pclk = ~pclk;
    // Hang guard, far above the under two hundred cycles needed
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end

    task tally_and_finish;
    begin
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    task chk(input [8*6-1:0] nm, input [31:0] got, input [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("[ERR] %0s exp %h got %h", nm, exp, got);
        end
    end
    endtask
    // One APB transfer, then an idle edge
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
    endtask
    task rdchk(input [11:0] a, input [31:0] exp);
    begin
        apb(1'b0, a, 32'h0);
        chk("rdata", rd, exp);
    end
    endtask
    // Index and priority fields worked out from the empty bits
    function [31:0] fix(input [31:0] s);
        reg [2:0] p;
        begin
            p = ~s[28:26];
            s[25:24] = s[26] ? 2'h0 : s[27] ? 2'h1 : s[28] ? 2'h2 : 2'h0;
            s[31:29] = ($countones(p) > 1) ? (p[2] ? 3'h4 : 3'h2) : 3'h0;
            fix = s;
        end
    endfunction

    task t_reset;
    begin
        st = 32'h1C000000;
        rdchk(ST, st);
        chk("empty", mbx_empty, 3'h7);
        rdchk(12'h0FC, 32'h0);
        chk("slverr", err, 1'b1);
    end
    endtask
    task t_flow;
    begin
        for (i = 0; i < 3; i = i + 1)
        begin
            eng.ev(0, 3'h1 << i);
            st[26 + i] = 1'b0;
            rdchk(ST, fix(st));
            eng.ev(2, 3'h1 << i);
            st[8 * i + 1] = 1'b1;
            rdchk(ST, fix(st));
            eng.ev(1, 3'h1 << i);
            st[26 + i] = 1'b1;
            st[8 * i] = 1'b1;
            rdchk(ST, fix(st));
        end
    end
    endtask
    task t_abort;
    begin
        apb(1'b1, ST, 32'h00800000);
        chk("abort", abort_req, 3'h0);
        eng.ev(0, 3'h4);
        st = st & 32'hEFFEFFFF;
        apb(1'b1, ST, 32'h00800000);
        chk("abort", abort_req, 3'h4);
        rdchk(ST, fix(st) | 32'h00800000);
        for (i = 0; i < 20 && abort_req !== 3'h0; i = i + 1)
            @(posedge pclk);
        st = st | 32'h10010000;
        rdchk(ST, fix(st));
    end
    endtask
    task t_w1c;
    begin
        eng.ev(3, 3'h2);
        eng.ev(4, 3'h2);
        st = st & 32'hFFFFFDFF | 32'h00000C00;
        rdchk(ST, fix(st));
        apb(1'b1, ST, 32'h0);
        apb(1'b1, ST, 32'h00707070);
        rdchk(ST, fix(st));
        pstrb <= 4'h0;
        apb(1'b1, ST, 32'h000F0F0F);
        pstrb <= 4'hF;
        rdchk(ST, fix(st));
        fork
            apb(1'b1, ST, 32'h000F0F0F);
            begin
                @(posedge pclk);
                eng.ev(3, 3'h2);
            end
        join
        st = st & 32'hFFF0F0F0 | 32'h00000400;
        rdchk(ST, fix(st));
    end
    endtask
    task t_prio;
    begin
        for (i = 0; i < 3; i = i + 1)
        begin
            eng.ev(0, 3'h1 << i);
            st[26 + i] = 1'b0;
            rdchk(ST, fix(st));
        end
        eng.ev(1, 3'h7);
        st = st | 32'h1C010101;
        rdchk(ST, fix(st));
    end
    endtask
    // Raise, mask and clear the interrupt
    task t_irq;
    begin
        apb(1'b1, `CANTMS_OFF_IRQ_CLR, 32'h000001FF);
        rdchk(`CANTMS_OFF_IRQ_STAT, 32'h0);
        apb(1'b1, `CANTMS_OFF_IRQ_EN, 32'h000001FF);
        chk("irq", irq, 1'b0);
        eng.ev(4, 3'h1);
        chk("irq", irq, 1'b1);
        rdchk(`CANTMS_OFF_IRQ_STAT, 32'h00000040);
        apb(1'b1, `CANTMS_OFF_IRQ_EN, 32'h000001BF);
        chk("irq", irq, 1'b0);
        apb(1'b1, `CANTMS_OFF_IRQ_CLR, 32'h00000040);
        rdchk(`CANTMS_OFF_IRQ_STAT, 32'h0);
        rdchk(`CANTMS_OFF_IRQ_EN, 32'h000001BF);
    end
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_flow;
        t_abort;
        t_w1c;
        t_prio;
        t_irq;
        tally_and_finish;
    end
endmodule // test_cantms_top
